// [radio_cfg_map.svh]
`ifndef RADIO_CFG_MAP_SVH
`define RADIO_CFG_MAP_SVH

`define CFG_WORD_BITS 24
`define CFG_SEL_LSB 0
`define CFG_SEL_MSB 1
`define CFG_SEL_REF 2'h0
`define CFG_SEL_RX 2'h1
`define CFG_SEL_TX 2'h2
`define CFG_SEL_MODE 2'h3
`define MODE_RX_ON_BIT 3
`define MODE_TX_ON_BIT 4
`define MODE_SLICER_BIT 16
`define CFG_WORD_RESET 24'h000000
`define REF_WORD_REQUIRED 24'h0043c0

`endif

// [radio_cfg_pkg.sv]
`default_nettype none
package radio_cfg_pkg;
  typedef logic [23:0] cfg_word_t;
  typedef enum logic [1:0] {
    SEL_REF = 2'h0,
    SEL_RX = 2'h1,
    SEL_TX = 2'h2,
    SEL_MODE = 2'h3
  } reg_sel_t;
endpackage
`default_nettype wire

// [radio_config_shift_port.sv]
`timescale 1ns/1ps
`default_nettype none
`include "radio_cfg_map.svh"

// Functional notes
// - four config registers, loaded only via shift clock, data and strobe
// - while strobe high, shift data in on each rising shift clock edge
// - two lowest bits of the last byte pick the target register
// - port carries tx channel, rx channel, tx on and rx on settings
// - rx and tx synthesizer words are held independently
// - select 00 ref, 01 rx synth, 10 tx synth, 11 mode
// - host shifts 24 bits; strobe falling edge loads the chosen register
// - separate rx/tx on bits; both off powers down, either on runs oscillator
// - mode bit enables the data slicer when set, audio when clear
module radio_config_shift_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_bit_in_i,
  input wire logic load_strobe_i,
  output radio_cfg_pkg::cfg_word_t ref_word_o,
  output radio_cfg_pkg::cfg_word_t rx_synth_o,
  output radio_cfg_pkg::cfg_word_t tx_synth_o,
  output radio_cfg_pkg::cfg_word_t mode_word_o,
  output logic receiver_on_o,
  output logic transmitter_on_o,
  output logic slicer_select_o,
  output logic osc_enable_o,
  output logic power_down_o,
  output logic ref_valid_o,
  output logic load_pulse_o
);
  import radio_cfg_pkg::*;

  // link domain, clocked by the host's shift clock
  // no reset here: the shift clock only runs inside a frame and the
  // contents are only consumed after a strobe fall has been seen
  cfg_word_t shift_r;
  cfg_word_t shift_nxt;

  always_comb begin
    shift_nxt = shift_r;
    if (load_strobe_i) begin
      shift_nxt = {shift_r[`CFG_WORD_BITS-2:0], serial_bit_in_i};
    end // strobe low holds the word
  end

  always_ff @(posedge shift_clk_i) begin
    shift_r <= shift_nxt;
  end

  // system domain
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // strobe crosses as a level; the word itself is frozen while the strobe
  // is low, so it is safe to sample once the synchronised fall is seen
  logic stb_s1_r;
  logic stb_s2_r;
  logic stb_d_r;
  logic stb_s1_nxt;
  logic stb_s2_nxt;
  logic stb_d_nxt;
  logic stb_fall;

  always_comb begin
    stb_s1_nxt = load_strobe_i;
    stb_s2_nxt = stb_s1_r;
    stb_d_nxt = stb_s2_r;
    stb_fall = stb_d_r && !stb_s2_r;
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stb_s1_r <= 1'b0;
      stb_s2_r <= 1'b0;
      stb_d_r <= 1'b0;
    end else begin
      stb_s1_r <= stb_s1_nxt;
      stb_s2_r <= stb_s2_nxt;
      stb_d_r <= stb_d_nxt;
    end
  end

  // one-cycle pulse, in step with the register update
  logic load_r;
  logic load_nxt;

  always_comb begin
    load_nxt = stb_fall;
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      load_r <= 1'b0;
    end else begin
      load_r <= load_nxt;
    end
  end

  // control registers, one per select code
  cfg_word_t ref_r;
  cfg_word_t ref_nxt;
  cfg_word_t rx_r;
  cfg_word_t rx_nxt;
  cfg_word_t tx_r;
  cfg_word_t tx_nxt;
  cfg_word_t mode_r;
  cfg_word_t mode_nxt;
  reg_sel_t sel;

  // the select sits in the last byte shifted, so it is still in place
  // when the strobe falls; a short frame still loads the last bits seen
  always_comb begin
    sel = reg_sel_t'(shift_r[`CFG_SEL_MSB:`CFG_SEL_LSB]);
    ref_nxt = ref_r;
    rx_nxt = rx_r;
    tx_nxt = tx_r;
    mode_nxt = mode_r;
    if (stb_fall) begin
      unique case (sel)
        SEL_REF: begin
          ref_nxt = shift_r;
        end
        SEL_RX: begin
          rx_nxt = shift_r;
        end
        SEL_TX: begin
          tx_nxt = shift_r;
        end
        SEL_MODE: begin
          mode_nxt = shift_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ref_r <= `CFG_WORD_RESET;
      rx_r <= `CFG_WORD_RESET;
      tx_r <= `CFG_WORD_RESET;
      mode_r <= `CFG_WORD_RESET;
    end else begin
      ref_r <= ref_nxt;
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
      mode_r <= mode_nxt;
    end
  end

  // mode decode is taken from the next mode word so the flags move in
  // the same cycle as mode_word_o and the load pulse
  logic rx_on_r;
  logic rx_on_nxt;
  logic tx_on_r;
  logic tx_on_nxt;
  logic slicer_r;
  logic slicer_nxt;
  logic osc_r;
  logic osc_nxt;
  logic pd_r;
  logic pd_nxt;
  logic ref_ok_r;
  logic ref_ok_nxt;

  always_comb begin
    rx_on_nxt = mode_nxt[`MODE_RX_ON_BIT];
    tx_on_nxt = mode_nxt[`MODE_TX_ON_BIT];
    slicer_nxt = mode_nxt[`MODE_SLICER_BIT];
    osc_nxt = rx_on_nxt || tx_on_nxt;
    // power-down is only flagged; nothing is gated off here
    pd_nxt = !(rx_on_nxt || tx_on_nxt);
    // flags a reference word equal to the one the synthesizer needs
    ref_ok_nxt = (ref_nxt == `REF_WORD_REQUIRED);
  end

  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rx_on_r <= 1'b0;
      tx_on_r <= 1'b0;
      slicer_r <= 1'b0;
      osc_r <= 1'b0;
      pd_r <= 1'b1;
      ref_ok_r <= 1'b0;
    end else begin
      rx_on_r <= rx_on_nxt;
      tx_on_r <= tx_on_nxt;
      slicer_r <= slicer_nxt;
      osc_r <= osc_nxt;
      pd_r <= pd_nxt;
      ref_ok_r <= ref_ok_nxt;
    end
  end

  assign ref_word_o = ref_r;
  assign rx_synth_o = rx_r;
  assign tx_synth_o = tx_r;
  assign mode_word_o = mode_r;
  assign receiver_on_o = rx_on_r;
  assign transmitter_on_o = tx_on_r;
  assign slicer_select_o = slicer_r;
  assign osc_enable_o = osc_r;
  assign power_down_o = pd_r;
  assign ref_valid_o = ref_ok_r;
  assign load_pulse_o = load_r;
endmodule
`default_nettype wire

// [cfg_port_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_port_sva (
  input wire logic clk_i,rst_n_i,load_pulse_o,power_down_o,osc_enable_o,
  input wire logic receiver_on_o,transmitter_on_o,slicer_select_o,
  input wire logic ref_valid_o,
  input wire radio_cfg_pkg::cfg_word_t ref_word_o,tx_synth_o,mode_word_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_pd; power_down_o!=(receiver_on_o|transmitter_on_o); endproperty
  a_pd: assert property (p_pd) else $error("pd");
  property p_osc; osc_enable_o!=power_down_o; endproperty
  a_osc: assert property (p_osc) else $error("osc");
  property p_rx; receiver_on_o==mode_word_o[3]; endproperty
  a_rx: assert property (p_rx) else $error("rx");
  property p_sl; slicer_select_o==mode_word_o[16]; endproperty
  a_sl: assert property (p_sl) else $error("sl");
  property p_rv; ref_valid_o==(ref_word_o==24'h0043c0); endproperty
  a_rv: assert property (p_rv) else $error("rv");
  property p_lp; load_pulse_o|=>!load_pulse_o; endproperty
  a_lp: assert property (p_lp) else $error("lp");
  property p_st; !load_pulse_o|->$stable(mode_word_o); endproperty
  a_st: assert property (p_st) else $error("st");
  property p_sel; $changed(tx_synth_o)|->tx_synth_o[1:0]==2'h2; endproperty
  a_sel: assert property (p_sel) else $error("sel");
  cover property (load_pulse_o&&slicer_select_o);
  cover property (load_pulse_o&&!ref_valid_o);
  cover property (power_down_o##1 osc_enable_o);
endmodule
bind radio_config_shift_port cfg_port_sva chk_u (.*);
`default_nettype wire

// [cfg_host.sv]
`timescale 1ns/1ps
`default_nettype none
module cfg_host (output logic sck_o, sdi_o, le_o);
  initial {sck_o,sdi_o,le_o}=3'h0;
  // clock stands still between frames; data idles at the inverted bit
  task automatic send(input logic [23:0] w,input logic en);
    le_o=en;
    for (int i=23;i>=0;i--) begin
      sdi_o=w[i];
      #3 sck_o=1'b1;
      #3 sck_o=1'b0;
    end
    #3 le_o=1'b0;
    sdi_o=~sdi_o;
  endtask
endmodule
`default_nettype wire

// [radio_config_shift_port_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module radio_config_shift_port_tb_top;
  import radio_cfg_pkg::*;
  logic clk_i=1'b0,rst_n_i=1'b0,receiver_on_o,transmitter_on_o,osc_enable_o;
  logic slicer_select_o,power_down_o,ref_valid_o,load_pulse_o;
  wire logic shift_clk_i,serial_bit_in_i,load_strobe_i;
  cfg_word_t ref_word_o,rx_synth_o,tx_synth_o,mode_word_o;
  logic [3:0][23:0] exp_w='0;
  int err_count=0,compares=0;
  radio_config_shift_port dut_u (.*);
  cfg_host host_u (.sck_o(shift_clk_i),.sdi_o(serial_bit_in_i),
    .le_o(load_strobe_i));
  initial forever #2.5 clk_i=~clk_i;
  task automatic chk(string n,logic [95:0] s,logic [95:0] e);
    compares++;
    if (s!==e) begin
      $display("ERROR %s exp %h got %h",n,e,s);
      err_count++;
    end
  endtask
  // en low clocks the word with the strobe down, so nothing may load
  task automatic ld(cfg_word_t w,logic en);
    host_u.send(w,en);
    if (en) exp_w[w[1:0]]=w;
    for (int n=0;n<12&&load_pulse_o!==1'b1;n++) @(posedge clk_i) #1;
    chk("pulse",96'(load_pulse_o),96'(en));
    chk("words",{mode_word_o,tx_synth_o,rx_synth_o,ref_word_o},
      exp_w);
    repeat (6) @(posedge clk_i) #1;
  endtask
  task automatic t_ref();
    ld(24'h0043c0,1'b1);
    chk("refok",96'(ref_valid_o),96'(1));
    ld(24'h00ff3c,1'b1);
    chk("refbad",96'(ref_valid_o),96'(0));
  endtask
  task automatic t_rst();
    rst_n_i=1'b0;
    @(posedge clk_i) #1;
    chk("rstw",{mode_word_o,tx_synth_o,rx_synth_o,ref_word_o},96'h0);
    chk("rstpd",96'(power_down_o),96'(1));
    rst_n_i=1'b1;
    exp_w='0;
    repeat (3) @(posedge clk_i) #1;
    ld(24'h3a5c86,1'b1);
  endtask
  task automatic t_synth();
    ld(24'h290b01,1'b1);
    ld(24'h3a5c86,1'b1);
    ld(24'h5a5a5b,1'b0);
  endtask
  task automatic t_mode();
    for (int i=0;i<4;i++) begin
      ld(cfg_word_t'(32'h27|i<<3|i%2<<16),1'b1);
      chk("rxon",96'(receiver_on_o),96'(i&1));
      chk("txon",96'(transmitter_on_o),96'(i>>1));
      chk("slicer",96'(slicer_select_o),96'(i%2));
      chk("osc",96'(osc_enable_o),96'(i!=0));
      chk("pd",96'(power_down_o),96'(i==0));
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d",err_count,compares);
    if (err_count==0&&compares>0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_n_i=1'b1;
    repeat (3) @(posedge clk_i) #1;
    t_ref();
    t_synth();
    t_mode();
    t_rst();
    close_out();
  end
  initial begin
    #20000 err_count++;
    close_out();
  end
endmodule
`default_nettype wire
